// [pps_sequencer.sv]
// Purpose: two-channel predefined protocol sequencer with wishbone registers
// Assumes: a protocol engine per channel does the serial work
// Notes: completion flags move only on scan_end, the host's end-of-scan strobe
`timescale 1ns/1ps

module pps_sequencer
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [14:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic scan_end,
	output pps_eng_req_type [1:0] eng_req,
	input wire pps_eng_rsp_type [1:0] eng_rsp,
	output logic [1:0] done_flag,
	output logic [1:0] err_flag,
	output logic [1:0] rx_clear,
	output logic [1:0] dtr,
	output logic [1:0] rts,
	output pps_hist_type [1:0] hist
);

	// ****************************************
	// helper functions
	// ****************************************

	// byte-lane merge of a 16-bit word
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = dat[15:8];
		end
	endfunction

	// special protocol numbers 201..207
	function automatic logic is_special(input logic [15:0] num);
		is_special = (num >= SP_RX_CLEAR) && (num <= SP_RTS_OFF);
	endfunction

	// ****************************************
	// wishbone slave
	// ****************************************
	logic ack_q; // ack, one cycle per request
	logic wr_en; // write takes effect at the edge that raises ack
	logic rd_take; // read data sampled at the same edge
	logic [31:0] rdat_d;
	logic [15:0] rd_ch [2]; // per-channel read word
	logic [1:0] busy; // channel busy view
	logic [1:0] pend; // held request view
	logic [3:0] cmd_op;
	logic cmd_chan;
	logic [3:0] cmd_cnt;
	logic [3:0] cmd_mode;
	logic cmd_wr;

	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
	assign rd_take = wb_cyc_i & wb_stb_i & ~ack_q;
	assign cmd_wr = wr_en && (wb_adr_i == IDX_CMD) && wb_sel_i[0];
	assign cmd_op = wb_dat_i[3:0];
	assign cmd_chan = wb_dat_i[4];
	assign cmd_cnt = wb_dat_i[11:8];
	assign cmd_mode = wb_dat_i[15:12];

	// ack follows every request after one wait cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rdat_d = 32'h0000_0000;
		rdat_d[15:0] = rd_ch[0] | rd_ch[1];
		if (wb_adr_i == IDX_CMD) begin
			rdat_d[1:0] = busy;
			rdat_d[3:2] = pend;
		end
	end

	// read data register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_take && !wb_we_i) begin
			wb_dat_o <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;

	// ****************************************
	// per-channel sequencer
	// ****************************************
	for (genvar i = 0; i < 2; i++) begin : g_ch
		localparam logic [14:0] A_LINE = (i == 0) ? IDX_LINE_CTL1 : IDX_LINE_CTL2;
		localparam logic [14:0] A_MON = (i == 0) ? IDX_MON_CTL1 : IDX_MON_CTL2;
		localparam logic [14:0] A_CAN = (i == 0) ? IDX_CANCEL1 : IDX_CANCEL2;
		localparam logic [14:0] A_STAT = (i == 0) ? IDX_STATUS1 : IDX_STATUS2;
		localparam logic [14:0] A_CB = (i == 0) ? IDX_CBLK1 : IDX_CBLK2;
		localparam logic [14:0] A_REJ = (i == 0) ? IDX_REJECT1 : IDX_REJECT2;

		pps_state_type st_q; // sequencer state
		logic [15:0] line_q; // line control word
		logic [15:0] mon_q; // monitoring control word
		logic [15:0] can_q; // cancellation word
		logic [15:0] rej_q; // outcome code of the last side request
		logic [3:0] mode_q; // channel mode
		logic [15:0] cb_q [CB_WORDS]; // control block
		logic [2:0] idx_q; // slot being run
		logic [3:0] cnt_q; // protocols asked for
		logic err_q; // request ended in error
		logic pend_q; // held execute request
		logic [3:0] pend_cnt_q;
		logic exec_now, start_now, bad_cnt, spec_now, run_now, cancel_now, last;
		logic [3:0] cnt_use;
		logic [15:0] num;
		logic [4:0] cb_off;
		logic cb_hit;
		logic [15:0] stat;

		assign cb_off = 5'(wb_adr_i - A_CB);
		assign cb_hit = (wb_adr_i >= A_CB) && (wb_adr_i < A_CB + 15'(CB_WORDS));
		assign exec_now = cmd_wr && (cmd_chan == 1'(i)) && (cmd_op == OP_EXEC);
		// a held request starts once idle
		assign start_now = (st_q == ST_IDLE) && (exec_now || pend_q);
		assign cnt_use = exec_now ? cmd_cnt : pend_cnt_q;
		// count must be 1 to 8
		assign bad_cnt = (cnt_use == 4'h0) || (cnt_use > MAX_PROTOS);
		// protocol numbers come from slots 2..9
		assign num = cb_q[CB_SLOT0 + 32'(idx_q)];
		assign spec_now = (st_q == ST_FETCH) && is_special(num);
		assign last = ({1'b0, idx_q} + 4'h1) == cnt_q;
		assign cancel_now = (st_q == ST_RUN) && (can_q == CANCEL_REQ) && (mode_q == MODE_PREDEF);
		assign run_now = (st_q == ST_RUN) && eng_rsp[i].done && !cancel_now;
		assign busy[i] = (st_q != ST_IDLE);
		assign pend[i] = pend_q;

		always_comb begin
			unique case (st_q)
				ST_IDLE: stat = STAT_IDLE;
				ST_FETCH, ST_RUN: stat = STAT_RUN;
				ST_CLOSE: stat = STAT_CLOSE;
			endcase
		end

		// channel read mux
		always_comb begin
			rd_ch[i] = 16'h0000;
			if (wb_adr_i == A_LINE) begin
				rd_ch[i] = line_q;
			end else if (wb_adr_i == A_MON) begin
				rd_ch[i] = mon_q;
			end else if (wb_adr_i == A_CAN) begin
				rd_ch[i] = can_q;
			end else if (wb_adr_i == A_STAT) begin
				rd_ch[i] = stat;
			end else if (wb_adr_i == A_REJ) begin
				rd_ch[i] = rej_q;
			end else if (cb_hit) begin
				rd_ch[i] = cb_q[cb_off];
			end
		end

		// sequencer; a failed protocol ends the request
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				st_q <= ST_IDLE;
				idx_q <= 3'h0;
				cnt_q <= 4'h0;
				err_q <= 1'b0;
			end else begin
				unique case (st_q)
					ST_IDLE: begin
						if (start_now) begin
							idx_q <= 3'h0;
							cnt_q <= cnt_use;
							err_q <= bad_cnt;
							st_q <= bad_cnt ? ST_CLOSE : ST_FETCH;
						end
					end
					ST_FETCH: begin
						// special protocols finish in this cycle
						if (spec_now && last) begin
							st_q <= ST_CLOSE;
						end else if (spec_now) begin
							idx_q <= idx_q + 3'h1;
						end else begin
							st_q <= ST_RUN;
						end
					end
					ST_RUN: begin
						// cancel ends the request with error
						if (cancel_now) begin
							err_q <= 1'b1;
							st_q <= ST_CLOSE;
						end else if (run_now && (eng_rsp[i].err || last)) begin
							err_q <= eng_rsp[i].err;
							st_q <= ST_CLOSE;
						end else if (run_now) begin
							idx_q <= idx_q + 3'h1;
							st_q <= ST_FETCH;
						end
					end
					ST_CLOSE: begin
						// channel frees as the flag rises
						if (scan_end) begin
							st_q <= ST_IDLE;
						end
					end
				endcase
			end
		end

		// held execute request; a new one while busy waits here
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				pend_q <= 1'b0;
				pend_cnt_q <= 4'h0;
			end else if (exec_now && (st_q != ST_IDLE)) begin
				// hold off until the active one completes
				pend_q <= 1'b1;
				pend_cnt_q <= cmd_cnt;
			end else if (start_now) begin
				pend_q <= 1'b0;
			end
		end

		// completion and error flags, moved only at end of scan
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				done_flag[i] <= 1'b0;
				err_flag[i] <= 1'b0;
			end else if (scan_end) begin
				// set at end of the finishing scan, cleared at the next
				done_flag[i] <= (st_q == ST_CLOSE);
				err_flag[i] <= (st_q == ST_CLOSE) && err_q;
			end
		end

		// engine requests, receive clear and history pulses
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				eng_req[i] <= '0;
				rx_clear[i] <= 1'b0;
				hist[i] <= '0;
			end else begin
				eng_req[i].start <= (st_q == ST_FETCH) && !spec_now;
				eng_req[i].abort <= cancel_now;
				if (st_q == ST_FETCH) begin
					eng_req[i].proto <= num;
				end
				// protocol 201 empties the receive buffer
				rx_clear[i] <= spec_now && (num == SP_RX_CLEAR);
				// keyword of the special protocol into history
				hist[i].valid <= spec_now;
				hist[i].keyword <= 3'(num - SP_RX_CLEAR);
			end
		end

		// line control word; dtr and rts follow its bits
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				line_q <= LINE_RST;
				dtr[i] <= 1'b0;
				rts[i] <= 1'b0;
			end else begin
				// specials 204..207 drive the line bits
				if (spec_now && (num >= SP_DTR_ON)) begin
					line_q[LINE_DTR_BIT] <= (num == SP_DTR_ON) ? 1'b1 : (num == SP_DTR_OFF) ? 1'b0 : line_q[LINE_DTR_BIT];
					line_q[LINE_RTS_BIT] <= (num == SP_RTS_ON) ? 1'b1 : (num == SP_RTS_OFF) ? 1'b0 : line_q[LINE_RTS_BIT];
				end else if (wr_en && (wb_adr_i == A_LINE)) begin
					line_q <= merge16(line_q, wb_dat_i, wb_sel_i);
				end
				dtr[i] <= line_q[LINE_DTR_BIT];
				rts[i] <= line_q[LINE_RTS_BIT];
			end
		end

		// monitoring word; the sequencer wins over a same-cycle bus write
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				mon_q <= MON_RST;
			end else if (spec_now && (num == SP_MON_START)) begin
				mon_q <= MON_ON;
			end else if (spec_now && (num == SP_MON_STOP)) begin
				mon_q <= MON_OFF;
			end else if (wr_en && (wb_adr_i == A_MON)) begin
				mon_q <= merge16(mon_q, wb_dat_i, wb_sel_i);
			end
		end

		// cancellation word; the done mark wins so it is never lost
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				can_q <= CANCEL_NONE;
			end else if (cancel_now) begin
				can_q <= CANCEL_DONE;
			end else if (wr_en && (wb_adr_i == A_CAN)) begin
				can_q <= merge16(can_q, wb_dat_i, wb_sel_i);
			end
		end

		// mode and side requests; needs nothing here, late data stays buffered
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				mode_q <= MODE_RST;
				rej_q <= RES_OK;
			end else if (cmd_wr && (cmd_chan == 1'(i))) begin
				if (cmd_op == OP_MODE && busy[i]) begin
					rej_q <= ERR_BUSY_MODE;
				end else if (cmd_op == OP_MODE) begin
					mode_q <= cmd_mode;
					rej_q <= RES_OK;
				end else if (cmd_op == OP_OTHER && mode_q == MODE_PREDEF) begin
					rej_q <= ERR_OTHER_PROTO;
				end else if (cmd_op != OP_EXEC) begin
					// store, state and receive buffer reads pass
					rej_q <= RES_OK;
				end
			end
		end

		// control block; results written by the sequencer win over the bus
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				for (int k = 0; k < CB_WORDS; k++) begin
					cb_q[k] <= 16'h0000;
				end
			end else if (start_now && bad_cnt) begin
				cb_q[CB_RESULT] <= ERR_OPERAND;
				cb_q[CB_COUNT] <= 16'h0000;
			end else if (spec_now || run_now || cancel_now) begin
				cb_q[CB_RESULT] <= cancel_now ? ERR_CANCELLED : (run_now && eng_rsp[i].err) ? eng_rsp[i].code : RES_OK;
				cb_q[CB_COUNT] <= 16'(idx_q) + 16'h0001;
				// packet number, zero for errors and specials
				cb_q[CB_PKT0 + 32'(idx_q)] <= (run_now && !eng_rsp[i].err) ? 16'(eng_rsp[i].packet) : 16'h0000;
			end else if (wr_en && cb_hit) begin
				cb_q[cb_off] <= merge16(cb_q[cb_off], wb_dat_i, wb_sel_i);
			end
		end
	end

endmodule

// [pps_pkg.sv]
// Purpose: shared constants and types of the protocol sequencer
// Assumes: 16-bit register words on a 32-bit classic Wishbone bus
// Notes: offsets are word indices, the byte address is four times the index
package pps_pkg;

	// ****************************************
	// register word indices
	// ****************************************
	localparam logic [14:0] IDX_LINE_CTL1 = 15'h0092;
	localparam logic [14:0] IDX_LINE_CTL2 = 15'h0132;
	localparam logic [14:0] IDX_MON_CTL1 = 15'h2018;
	localparam logic [14:0] IDX_MON_CTL2 = 15'h2118;
	localparam logic [14:0] IDX_CANCEL1 = 15'h4040;
	localparam logic [14:0] IDX_STATUS1 = 15'h4041;
	localparam logic [14:0] IDX_CANCEL2 = 15'h4050;
	localparam logic [14:0] IDX_STATUS2 = 15'h4051;
	localparam logic [14:0] IDX_CBLK1 = 15'h4200; // control block, 18 words
	localparam logic [14:0] IDX_CBLK2 = 15'h4220;
	localparam logic [14:0] IDX_CMD = 15'h4300; // request port and busy view
	localparam logic [14:0] IDX_REJECT1 = 15'h4301; // code of last side request
	localparam logic [14:0] IDX_REJECT2 = 15'h4302;

	// control block layout
	localparam int CB_RESULT = 0;
	localparam int CB_COUNT = 1;
	localparam int CB_SLOT0 = 2;
	localparam int CB_PKT0 = 10;
	localparam int CB_WORDS = 18;
	localparam logic [3:0] MAX_PROTOS = 4'h8;

	// special protocol numbers
	localparam logic [15:0] SP_RX_CLEAR = 16'h00c9;
	localparam logic [15:0] SP_MON_START = 16'h00ca;
	localparam logic [15:0] SP_MON_STOP = 16'h00cb;
	localparam logic [15:0] SP_DTR_ON = 16'h00cc;
	localparam logic [15:0] SP_DTR_OFF = 16'h00cd;
	localparam logic [15:0] SP_RTS_ON = 16'h00ce;
	localparam logic [15:0] SP_RTS_OFF = 16'h00cf;

	// word values and bit positions
	localparam logic [15:0] MON_ON = 16'h0001;
	localparam logic [15:0] MON_OFF = 16'h0000;
	localparam int LINE_DTR_BIT = 0;
	localparam int LINE_RTS_BIT = 1;
	localparam logic [15:0] CANCEL_NONE = 16'h0000;
	localparam logic [15:0] CANCEL_REQ = 16'h0001;
	localparam logic [15:0] CANCEL_DONE = 16'h0002;
	localparam logic [15:0] ERR_BUSY_MODE = 16'h7ff0;
	localparam logic [15:0] ERR_OTHER_PROTO = 16'h7ff2;
	localparam logic [15:0] ERR_CANCELLED = 16'h7f10;
	localparam logic [15:0] ERR_OPERAND = 16'h7f11;
	localparam logic [15:0] RES_OK = 16'h0000;
	localparam logic [15:0] LINE_RST = 16'h0000;
	localparam logic [15:0] MON_RST = 16'h0000;
	localparam logic [3:0] MODE_PREDEF = 4'h1;
	localparam logic [3:0] MODE_RST = 4'h1;

	// execution status word values
	localparam logic [15:0] STAT_IDLE = 16'h0000;
	localparam logic [15:0] STAT_RUN = 16'h0001;
	localparam logic [15:0] STAT_CLOSE = 16'h0002;

	// request port operations
	localparam logic [3:0] OP_EXEC = 4'h1;
	localparam logic [3:0] OP_MODE = 4'h2;
	localparam logic [3:0] OP_OTHER = 4'h3;
	localparam logic [3:0] OP_RXREAD = 4'h4;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RUN, ST_CLOSE} pps_state_type;

	typedef struct packed {
		logic start; // one-cycle pulse, runs proto from the store
		logic abort; // one-cycle pulse, kills the running protocol
		logic [15:0] proto;
	} pps_eng_req_type;

	typedef struct packed {
		logic done; // one-cycle pulse
		logic err;
		logic [15:0] code;
		logic [4:0] packet;
	} pps_eng_rsp_type;

	typedef struct packed {
		logic valid; // one cycle per special protocol; adjacent specials give back-to-back cycles
		logic [2:0] keyword; // 0..6 for protocols 201..207
	} pps_hist_type;

endpackage

// [pps_sequencer_properties.sv]
// Purpose: port-level checks on the protocol sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every sequencer instance
`timescale 1ns/1ps

module pps_sequencer_props
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [14:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic scan_end,
	input wire pps_eng_req_type [1:0] eng_req,
	input wire pps_eng_rsp_type [1:0] eng_rsp,
	input wire logic [1:0] done_flag,
	input wire logic [1:0] err_flag,
	input wire logic [1:0] rx_clear,
	input wire pps_hist_type [1:0] hist
);
	// ********
	// helper state
	// ********
	logic [1:0] run_q; // engine holds a protocol
	logic [1:0] st; // start pulses
	logic [1:0] ab; // abort pulses
	logic canc_wr; // cancel requested on channel one
	logic mode_ok_q; // channel one taken to be in predefined mode
	assign st = {eng_req[1].start, eng_req[0].start};
	assign ab = {eng_req[1].abort, eng_req[0].abort};
	assign canc_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == IDX_CANCEL1
		&& wb_dat_i[15:0] == CANCEL_REQ;
	// a protocol is in flight from start until answer or abort
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 2'b00;
		end else begin
			run_q <= (run_q | st) & ~{eng_rsp[1].done, eng_rsp[0].done} & ~ab;
		end
	end
	// mode follows accepted mode changes on channel one; one made while the engine holds a protocol is refused and left out
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_ok_q <= 1'b1;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == IDX_CMD
			&& wb_dat_i[4:0] == {1'b0, OP_MODE} && !run_q[0]) begin
			mode_ok_q <= (wb_dat_i[15:12] == MODE_PREDEF);
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	// ********
	// assertions
	// ********
	a_ack_one_wait: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus answer not one cycle after request");
	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer held too long");
	a_err_needs_done: assert property ((err_flag & ~done_flag) == 2'b00)
		else $error("error flag without completion flag");
	a_flags_on_scan: assert property (!$stable(done_flag) |-> $past(scan_end))
		else $error("completion flag moved off end of scan");
	a_done_one_scan: assert property (scan_end |=> ((done_flag & $past(done_flag)) == 2'b00))
		else $error("completion flag longer than one scan");
	a_start_when_free: assert property ((st & run_q) == 2'b00)
		else $error("engine started while busy");
	a_start_single_pulse: assert property ((st != 2'b00) |=> ((st & $past(st)) == 2'b00))
		else $error("start pulse too long");
	a_abort_on_cancel: assert property ((canc_wr && run_q[0] && mode_ok_q) |=> ab[0])
		else $error("cancel did not abort the engine");
	a_abort_only_busy: assert property ((ab & ~run_q) == 2'b00)
		else $error("abort with no protocol running");
	a_rx_clear_pulse: assert property ((rx_clear != 2'b00) |=> ((rx_clear & $past(rx_clear)) == 2'b00))
		else $error("receive clear pulse too long");
	a_hist_key_range: assert property (!(hist[0].valid && hist[0].keyword == 3'h7) &&
		!(hist[1].valid && hist[1].keyword == 3'h7) &&
		!(rx_clear[0] && !(hist[0].valid && hist[0].keyword == 3'h0)) &&
		!(rx_clear[1] && !(hist[1].valid && hist[1].keyword == 3'h0)))
		else $error("history keyword wrong");
endmodule

bind pps_sequencer pps_sequencer_props i_props (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.scan_end(scan_end), .eng_req(eng_req), .eng_rsp(eng_rsp), .done_flag(done_flag), .err_flag(err_flag),
	.rx_clear(rx_clear), .hist(hist));

// [pps_engine_model.sv]
// Purpose: behavioural protocol engine for one channel
// Assumes: answers lat+1 cycles after the start pulse, one protocol number fails
// Notes: answer fields are scrambled outside the answer cycle
`timescale 1ns/1ps

module pps_engine_model
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire pps_eng_req_type req,
	input wire logic [7:0] lat,
	input wire logic [15:0] fail_num,
	output pps_eng_rsp_type rsp
);
	logic busy_q; // protocol in flight
	logic [7:0] cnt_q; // cycles left to answer
	logic [15:0] proto_q; // protocol being run
	logic hit; // answer cycle
	logic bad; // this protocol fails
	// count down; an abort drops the protocol with no answer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			proto_q <= 16'h0000;
		end else if (req.abort) begin
			busy_q <= 1'b0;
		end else if (req.start) begin
			busy_q <= 1'b1;
			cnt_q <= lat;
			proto_q <= req.proto;
		end else if (busy_q) begin
			busy_q <= (cnt_q != 8'h00);
			cnt_q <= cnt_q - 8'h01;
		end
	end
	assign hit = busy_q && cnt_q == 8'h00;
	assign bad = proto_q == fail_num;
	// packet stays nonzero on failure so the sequencer must zero it
	assign rsp.done = hit;
	assign rsp.err = hit ? bad : ~bad;
	assign rsp.code = (hit == bad) ? 16'h7001 : 16'h0000;
	assign rsp.packet = hit ? {1'b0, proto_q[3:0]} + 5'h01 : ~proto_q[4:0];
endmodule

// [pps_tb.sv]
// Purpose: self-checking bench of the protocol sequencer
// Assumes: engine models on both channels, scan of 16 cycles
// Notes: random sequences plus fixed corner cases
`timescale 1ns/1ps

module tb;
	import pps_pkg::*;
	localparam int SCAN = 16; // cycles per host scan
	localparam logic [15:0] FAIL_NUM = 16'h0099; // protocol the engine fails
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [14:0] wb_adr_i = 15'h0000;
	logic [3:0] wb_sel_i = 4'h3;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic scan_end = 1'b0;
	pps_eng_req_type [1:0] eng_req;
	pps_eng_rsp_type [1:0] eng_rsp;
	logic [1:0] done_flag, err_flag, rx_clear, dtr, rts;
	pps_hist_type [1:0] hist;
	logic [7:0] lat [2] = '{8'h03, 8'h03}; // engine reply times
	logic [6:0] kw_mask [2] = '{7'h00, 7'h00}; // keywords seen in history
	int n_fail = 0, tests_run = 0, scan_cnt = 0;
	int starts [2] = '{0, 0}, rxc [2] = '{0, 0}, sn [2];
	logic [31:0] rnd_q = 32'h48618e26; // random state, fixed seed
	logic [15:0] nums [8]; // protocol numbers of the next request
	logic [15:0] junk;
	always #50 clk = ~clk;
	// host scan: one end-of-scan strobe every SCAN cycles
	always @(posedge clk) begin
		scan_cnt <= (scan_cnt == SCAN - 1) ? 0 : scan_cnt + 1;
		scan_end <= (scan_cnt == SCAN - 1);
	end
	// watch engine starts, clear pulses and history keywords
	always @(posedge clk) begin
		for (int c = 0; c < 2; c++) begin
			if (eng_req[c].start === 1'b1) starts[c]++;
			if (rx_clear[c] === 1'b1) rxc[c]++;
			if (hist[c].valid === 1'b1) kw_mask[c][hist[c].keyword] = 1'b1;
		end
	end
	pps_sequencer i_pps_sequencer (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .scan_end(scan_end), .eng_req(eng_req), .eng_rsp(eng_rsp), .done_flag(done_flag),
		.err_flag(err_flag), .rx_clear(rx_clear), .dtr(dtr), .rts(rts), .hist(hist));
	for (genvar g = 0; g < 2; g++) begin : g_eng
		pps_engine_model i_pps_engine_model (.clk(clk), .rstn(rstn), .req(eng_req[g]), .lat(lat[g]),
			.fail_num(FAIL_NUM), .rsp(eng_rsp[g]));
	end
	// ********
	// helpers
	// ********
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	function automatic logic [14:0] cbase(input int ch);
		return ch ? IDX_CBLK2 : IDX_CBLK1;
	endfunction
	// failed and special protocols store no packet number
	function automatic logic [15:0] exp_pkt(input logic [15:0] p);
		if (p == FAIL_NUM || p >= SP_RX_CLEAR) return 16'h0000;
		return {11'h000, {1'b0, p[3:0]} + 5'h01};
	endfunction
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task timeout;
		n_fail++;
		$display("MISMATCH at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
		print_verdict();
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle: hold everything until ack is sampled
	task automatic wb_cycle(input logic we, input logic [14:0] adr, input logic [15:0] dat, output logic [15:0] rd);
		int i;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {16'h0000, dat};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 20) timeout();
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task wr(input logic [14:0] a, input logic [15:0] d);
		wb_cycle(1'b1, a, d, junk);
	endtask
	task automatic chk_rd(input logic [14:0] a, input logic [15:0] exp);
		logic [15:0] v;
		wb_cycle(1'b0, a, 16'h0000, v);
		chk(v, exp);
	endtask
	task automatic send(input int ch, input int n);
		for (int k = 0; k < n && k < 8; k++) wr(15'(cbase(ch) + CB_SLOT0 + k), nums[k]);
		wr(IDX_CMD, {4'h0, 4'(n), 3'b000, 1'(ch), OP_EXEC});
	endtask
	task side(input int ch, input logic [3:0] op, input logic [15:0] exp);
		wr(IDX_CMD, {4'h2, 4'h0, 3'b000, 1'(ch), op});
		chk_rd(ch ? IDX_REJECT2 : IDX_REJECT1, exp);
	endtask
	// wait for the completion flag, take the error flag beside it
	task automatic wait_done(input int ch, output logic e);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (done_flag[ch] === 1'b1) break;
		end
		if (i == 3000) timeout();
		e = err_flag[ch];
		repeat (SCAN + 1) @(posedge clk);
	endtask
	task automatic chk_cb(input int ch, input int n, input logic [15:0] res);
		chk_rd(15'(cbase(ch) + CB_RESULT), res);
		chk_rd(15'(cbase(ch) + CB_COUNT), 16'(n));
		for (int k = 0; k < n; k++) chk_rd(15'(cbase(ch) + CB_PKT0 + k), exp_pkt(nums[k]));
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		int ch, n;
		logic e;
		logic [6:0] m;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		chk_rd(IDX_LINE_CTL1, LINE_RST);
		chk_rd(IDX_MON_CTL2, MON_RST);
		chk_rd(IDX_CANCEL1, CANCEL_NONE);
		chk_rd(IDX_STATUS1, STAT_IDLE);
		chk_rd(15'h7abc, 16'h0000);
		// random sequences on alternate channels, the first one full length
		for (int r = 0; r < 6; r++) begin
			ch = r % 2;
			rnd_q = lfsr_next(rnd_q);
			n = (r == 0) ? 8 : rnd_q[2:0] + 1;
			lat[ch] = {4'h0, rnd_q[6:3]} + 8'h01;
			for (int k = 0; k < 8; k++) begin
				rnd_q = lfsr_next(rnd_q);
				nums[k] = {10'h000, rnd_q[5:0]} + 16'h0001;
			end
			sn = starts;
			send(ch, n);
			wait_done(ch, e);
			chk(16'(e), 16'h0000);
			chk(16'(starts[ch] - sn[ch]), 16'(n));
			chk(16'(starts[1 - ch] - sn[1 - ch]), 16'h0000);
			chk_cb(ch, n, RES_OK);
		end
		// failure in the second slot stops the sequence
		nums[0] = 16'h0005;
		nums[1] = FAIL_NUM;
		sn = starts;
		send(0, 4);
		wait_done(0, e);
		chk(16'(e), 16'h0001);
		chk(16'(starts[0] - sn[0]), 16'h0002);
		chk_cb(0, 2, 16'h7001);
		// special protocols placed in the number slots
		nums[0] = SP_MON_START;
		nums[1] = SP_DTR_ON;
		nums[2] = SP_RTS_ON;
		nums[3] = SP_RX_CLEAR;
		kw_mask[1] = 7'h00;
		m = 7'h00;
		for (int k = 0; k < 4; k++) m[nums[k] - SP_RX_CLEAR] = 1'b1;
		sn = starts;
		rxc[1] = 0;
		send(1, 4);
		wait_done(1, e);
		chk_rd(IDX_MON_CTL2, MON_ON);
		chk_rd(IDX_LINE_CTL2, 16'h0003);
		chk({14'h0000, rts[1], dtr[1]}, 16'h0003);
		chk(16'(rxc[1]), 16'h0001);
		chk({9'h000, kw_mask[1]}, {9'h000, m});
		chk(16'(starts[1] - sn[1]), 16'h0000);
		chk_cb(1, 4, RES_OK);
		nums[0] = SP_MON_STOP;
		nums[1] = SP_DTR_OFF;
		nums[2] = SP_RTS_OFF;
		send(1, 3);
		wait_done(1, e);
		chk_rd(IDX_MON_CTL2, MON_OFF);
		chk_rd(IDX_LINE_CTL2, 16'h0000);
		chk({14'h0000, rts[1], dtr[1]}, 16'h0000);
		// counts just outside the legal range
		for (int k = 0; k < 2; k++) begin
			send(0, k ? 9 : 0);
			wait_done(0, e);
			chk(16'(e), 16'h0001);
			chk_cb(0, 0, ERR_OPERAND);
		end
		// slow protocol: side requests, other channel, then cancel
		lat[0] = 8'd200;
		lat[1] = 8'd2;
		for (int k = 0; k < 3; k++) nums[k] = 16'h0010 + 16'(k);
		sn = starts;
		send(0, 3);
		for (int i = 0; i < 100 && starts[0] == sn[0]; i++) @(posedge clk);
		chk(16'(starts[0] - sn[0]), 16'h0001);
		chk_rd(IDX_STATUS1, STAT_RUN);
		side(0, OP_MODE, ERR_BUSY_MODE);
		side(0, OP_OTHER, ERR_OTHER_PROTO);
		side(0, OP_RXREAD, RES_OK);
		send(1, 1);
		wait_done(1, e);
		chk(16'(e), 16'h0000);
		wr(IDX_CANCEL1, CANCEL_REQ);
		wait_done(0, e);
		chk(16'(e), 16'h0001);
		chk(16'(starts[0] - sn[0]), 16'h0001);
		chk_rd(IDX_CANCEL1, CANCEL_DONE);
		chk_rd(15'(cbase(0) + CB_RESULT), ERR_CANCELLED);
		// cancel word back to none before any new execute
		wr(IDX_CANCEL1, CANCEL_NONE);
		wr(IDX_CANCEL2, CANCEL_REQ);
		chk_rd(IDX_CANCEL2, CANCEL_REQ);
		wr(IDX_CANCEL2, CANCEL_NONE);
		// second execute on a busy channel is held, then run
		lat[0] = 8'd20;
		sn = starts;
		send(0, 1);
		send(0, 1);
		chk_rd(IDX_CMD, 16'h0005);
		wait_done(0, e);
		wait_done(0, e);
		chk(16'(starts[0] - sn[0]), 16'h0002);
		// another mode: cancel word is ignored and foreign requests pass
		side(0, OP_MODE, RES_OK);
		send(0, 1);
		wr(IDX_CANCEL1, CANCEL_REQ);
		wait_done(0, e);
		chk(16'(e), 16'h0000);
		chk_rd(IDX_CANCEL1, CANCEL_REQ);
		side(0, OP_OTHER, RES_OK);
		print_verdict();
	end
endmodule
